//--- rtl/dual_port_gpio.sv
// Dual general-purpose port block with change detection, behind AXI4-Lite
//--------------------------------------------------------------------
//--------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
`include "gpio_params.svh"
module dual_port_gpio import gpio_pkg::*; #(
    parameter int ADDR_W = 12
) (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // AXI4-Lite write channels
    input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    // AXI4-Lite read channels
    input wire logic [ADDR_W-1:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    // First port pins
    input wire logic [5:0] first_pin_in,
    output logic [5:0] first_pin_out,
    output logic [5:0] first_pin_oe_n_out,
    // Second port pins and pull-ups
    input wire logic [7:0] second_pin_in,
    output logic [7:0] second_pin_out,
    output logic [7:0] second_pin_oe_n_out,
    output logic [7:0] second_pullup_en_out,
    // Comparator and reference links
    input wire logic comparator_one_result_in,
    input wire logic comparator_two_result_in,
    output logic [5:0] analog_select_out,
    output logic comparator_ground_out,
    output logic [2:0] comparator_mode_out,
    output logic comparator_input_switch_out,
    output logic [7:0] vref_control_out,
    // Timer clock, change request and wake
    output logic timer_external_clock_out,
    output logic second_port_change_request_out,
    output logic wake_request_out
);
    //----------------------------------------------------------------
    // Input synchronisers
    //----------------------------------------------------------------
    logic [15:0] synced; // Filtered pin and comparator levels
    logic [5:0] first_lvl; // First port pin levels
    logic [7:0] second_lvl; // Second port pin levels
    logic [1:0] cmp_lvl; // Comparator results

    pin_sync #(
        .W(16)
    ) u_sync (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .raw_in({comparator_two_result_in, comparator_one_result_in,
                 second_pin_in, first_pin_in}),
        .level_out(synced)
    );
    assign first_lvl = synced[5:0];
    assign second_lvl = synced[13:6];
    assign cmp_lvl = synced[15:14];

    //----------------------------------------------------------------
    // State and decode
    //----------------------------------------------------------------
    gpio_state_t q; // Registered state
    gpio_state_t d; // Next state
    logic wr_fire; // Write taken this cycle
    logic rd_fire; // Read taken this cycle
    logic [7:0] wr_idx; // Register index of the write
    logic [7:0] rd_idx; // Register index of the read
    logic [7:0] wbyte; // Low byte lane of write data
    logic wlane; // Low byte lane enabled
    logic [5:0] an_mask; // Pins whose digital input is off
    logic cmp_outputs; // Comparator outputs on pins
    logic [5:0] first_read; // First port value as software sees it
    logic [5:0] first_drive; // Value offered to first port drivers
    logic [3:0] mismatch; // Per-pin change against last read or write of the port
    logic change_clear; // Software clears the change flag
    pin_drive_t second_drv; // Second port drivers

    // Write waits for both address and data, one at a time
    assign wr_fire = s_axi_awvalid_in & s_axi_wvalid_in & ~q.bvalid;
    assign rd_fire = s_axi_arvalid_in & ~q.rvalid;
    assign wr_idx = s_axi_awaddr_in[9:2];
    assign rd_idx = s_axi_araddr_in[9:2];
    assign wbyte = s_axi_wdata_in[7:0];
    assign wlane = s_axi_wstrb_in[0];

    //----------------------------------------------------------------
    // Pin function selection
    //----------------------------------------------------------------
    // Analog pins lose their digital path; off mode frees all but bit two when the reference output is on
    always_comb begin
        an_mask = (q.cmp_mode == `CMP_MODE_OFF) ? 6'h00 : `CMP_ANALOG_MASK;
        if (q.vref_ctl[`VREF_OUT_EN_BIT]) begin
            an_mask = an_mask | `VREF_PIN_MASK;
        end
    end
    assign cmp_outputs = (q.cmp_mode == `CMP_MODE_OUTPUTS);
    assign first_read = first_lvl & ~an_mask;

    // In outputs mode, comparator results replace the latch on bits three and four
    always_comb begin
        first_drive = q.first_latch;
        if (cmp_outputs) begin
            first_drive[3] = cmp_lvl[0];
            first_drive[4] = cmp_lvl[1];
        end
    end

    //----------------------------------------------------------------
    // Change detection on the upper second port pins
    //----------------------------------------------------------------
    // Only upper pins set as inputs take part in the comparison
    for (genvar g = 0; g < 4; g++) begin : g_mismatch
        assign mismatch[g] = q.second_dir[g + 4]
            & (second_lvl[g + 4] ^ q.old_upper[g]);
    end
    // Writing zero to bit zero clears; writing one cannot fake a change
    assign change_clear = wr_fire & wlane & (wr_idx == `IDX_CHANGE_CTRL)
        & ~wbyte[0];

    //----------------------------------------------------------------
    // Next state
    //----------------------------------------------------------------
    // Register writes, read answers and flag upkeep in one place
    always_comb begin
        d = q;
        if (q.bvalid && s_axi_bready_in) begin
            d.bvalid = 1'b0;
        end
        if (q.rvalid && s_axi_rready_in) begin
            d.rvalid = 1'b0;
        end
        // Writes land in the cycle both halves are offered
        if (wr_fire) begin
            d.bvalid = 1'b1;
            d.bresp = `RESP_OKAY;
            case (wr_idx)
                `IDX_FIRST_DATA: begin
                    // Untouched lane stores the pins back, as a merge would
                    d.first_latch = wlane ? wbyte[5:0] : first_read;
                end
                `IDX_SECOND_DATA: begin
                    d.second_latch = wlane ? wbyte : second_lvl;
                    d.old_upper = second_lvl[7:4];
                end
                `IDX_CHANGE_CTRL: begin
                    // Flag clear is handled with the flag below
                end
                `IDX_COMPARATOR: begin
                    // Result bits are read-only
                    if (wlane) begin
                        d.cmp_mode = wbyte[2:0];
                        d.cmp_cis = wbyte[3];
                    end
                end
                `IDX_OPTION: begin
                    if (wlane) begin
                        d.option = wbyte;
                    end
                end
                `IDX_FIRST_DIR: begin
                    if (wlane) begin
                        d.first_dir = wbyte[5:0];
                    end
                end
                `IDX_SECOND_DIR: begin
                    if (wlane) begin
                        d.second_dir = wbyte;
                    end
                end
                `IDX_VREF: begin
                    // Bit four is not implemented
                    if (wlane) begin
                        d.vref_ctl = wbyte & `VREF_WR_MASK;
                    end
                end
                default: begin
                    // Nothing lives here
                    d.bresp = `RESP_SLVERR;
                end
            endcase
        end
        // Read answer is captured into flip-flops
        if (rd_fire) begin
            d.rvalid = 1'b1;
            d.rresp = `RESP_OKAY;
            d.rdata = 32'h0000_0000;
            case (rd_idx)
                `IDX_FIRST_DATA: begin
                    // Pins, with analog inputs forced to zero
                    d.rdata[7:0] = {2'b00, first_read};
                end
                `IDX_SECOND_DATA: begin
                    d.rdata[7:0] = second_lvl;
                    d.old_upper = second_lvl[7:4];
                end
                `IDX_CHANGE_CTRL: begin
                    d.rdata[0] = q.change_flag;
                end
                `IDX_COMPARATOR: begin
                    d.rdata[7:0] = {cmp_lvl[1], cmp_lvl[0], 2'b00, q.cmp_cis, q.cmp_mode};
                end
                `IDX_OPTION: begin
                    d.rdata[7:0] = q.option;
                end
                `IDX_FIRST_DIR: begin
                    d.rdata[7:0] = {2'b00, q.first_dir};
                end
                `IDX_SECOND_DIR: begin
                    d.rdata[7:0] = q.second_dir;
                end
                `IDX_VREF: begin
                    d.rdata[7:0] = q.vref_ctl;
                end
                default: begin
                    d.rresp = `RESP_SLVERR;
                end
            endcase
        end
        // Set wins over a clear in the same cycle
        d.change_flag = (|mismatch) | (q.change_flag & ~change_clear);
    end

    //----------------------------------------------------------------
    // State register
    //----------------------------------------------------------------
    // Every reset is treated as power-on: pull-ups off, pins input
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            q.first_latch <= 6'h00;
            q.first_dir <= `RST_FIRST_DIR;
            q.cmp_mode <= `RST_CMP_MODE;
            q.cmp_cis <= 1'b0;
            q.vref_ctl <= `RST_VREF;
            q.second_latch <= 8'h00;
            q.second_dir <= `RST_SECOND_DIR;
            q.option <= `RST_OPTION;
            q.old_upper <= 4'h0;
            q.change_flag <= 1'b0;
            q.bvalid <= 1'b0;
            q.bresp <= 2'h0;
            q.rvalid <= 1'b0;
            q.rdata <= 32'h0000_0000;
            q.rresp <= 2'h0;
        end else begin
            q <= d;
        end
    end

    //----------------------------------------------------------------
    // Bus outputs
    //----------------------------------------------------------------
    // Ready is combinational, so a channel is taken the cycle it is offered with no answer pending and, for writes, both halves offered
    assign s_axi_awready_out = wr_fire;
    assign s_axi_wready_out = wr_fire;
    assign s_axi_bvalid_out = q.bvalid;
    assign s_axi_bresp_out = q.bresp;
    assign s_axi_arready_out = rd_fire;
    assign s_axi_rvalid_out = q.rvalid;
    assign s_axi_rdata_out = q.rdata;
    assign s_axi_rresp_out = q.rresp;

    //----------------------------------------------------------------
    // Pin drivers
    //----------------------------------------------------------------
    // Direction rules every pin, comparator inputs included
    always_comb begin
        first_pin_out = first_drive;
        first_pin_oe_n_out = q.first_dir;
        // Bit four only ever pulls low; a one releases it
        first_pin_out[`CMP_OPEN_DRAIN_BIT] = 1'b0;
        first_pin_oe_n_out[`CMP_OPEN_DRAIN_BIT] = q.first_dir[4] | first_drive[4];
    end

    // Second port drives its latch where direction allows
    assign second_drv.value = q.second_latch;
    assign second_drv.oe_n = q.second_dir;
    assign second_pin_out = second_drv.value;
    assign second_pin_oe_n_out = second_drv.oe_n;
    // One shared enable, but an output pin never keeps its pull-up
    for (genvar p = 0; p < 8; p++) begin : g_pullup
        assign second_pullup_en_out[p] = ~q.option[`OPT_PULLUP_N_BIT]
            & q.second_dir[p];
    end

    // Comparator, reference, timer and request lines
    assign analog_select_out = an_mask;
    assign comparator_ground_out = (q.cmp_mode == `CMP_MODE_RESET);
    assign comparator_mode_out = q.cmp_mode;
    assign comparator_input_switch_out = q.cmp_cis;
    assign vref_control_out = q.vref_ctl;
    assign timer_external_clock_out = first_lvl[4];
    assign second_port_change_request_out = q.change_flag;
    assign wake_request_out = q.change_flag;

    //----------------------------------------------------------------
    // Checks
    //----------------------------------------------------------------
    // Open-drain bit four never drives high
    open_drain_low_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        !first_pin_out[`CMP_OPEN_DRAIN_BIT])
        else $error("first port bit four driven high");
    // A first port pin set as input is never driven
    input_pin_hiz_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (first_pin_oe_n_out & q.first_dir) == q.first_dir)
        else $error("first port input pin driven");
    // Output pins of the second port lose their pull-up
    pullup_output_off_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (second_pullup_en_out & ~q.second_dir) == 8'h00)
        else $error("pull-up left on an output pin");
    // Data read answers with the masked pin levels
    first_read_pins_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        rd_fire && (rd_idx == `IDX_FIRST_DATA) |=> s_axi_rdata_out == {26'h0, $past(first_read)})
        else $error("first port read not the pin levels");
    // Data write lands in the latch
    first_write_latch_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        wr_fire && wlane && (wr_idx == `IDX_FIRST_DATA) |=> q.first_latch == $past(wbyte[5:0]))
        else $error("first port write missed the latch");
    // A mismatch always raises the flag
    mismatch_sets_flag_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (|mismatch) |=> q.change_flag)
        else $error("mismatch did not set the change flag");
    // The flag stays until software clears it
    flag_sticky_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        q.change_flag && !change_clear |=> q.change_flag)
        else $error("change flag dropped without a clear");
endmodule // dual_port_gpio
`default_nettype wire

//--- rtl/gpio_params.svh
// Register indices, field positions, reset values and modes of the port block
`ifndef GPIO_PARAMS_SVH
`define GPIO_PARAMS_SVH
// Register indices; the byte address is four times the index
`define IDX_FIRST_DATA 8'h05
`define IDX_SECOND_DATA 8'h06
`define IDX_CHANGE_CTRL 8'h0b
`define IDX_COMPARATOR 8'h1f
`define IDX_OPTION 8'h81
`define IDX_FIRST_DIR 8'h85
`define IDX_SECOND_DIR 8'h86
`define IDX_VREF 8'h9f
// Reset values
`define RST_FIRST_DIR 6'h3f
`define RST_SECOND_DIR 8'hff
`define RST_OPTION 8'hff
`define RST_VREF 8'h00
`define RST_CMP_MODE 3'h0
// Field positions and masks
`define OPT_PULLUP_N_BIT 7
`define VREF_OUT_EN_BIT 6
`define VREF_WR_MASK 8'hef
`define CMP_OPEN_DRAIN_BIT 4
// Comparator modes with a fixed pin meaning
`define CMP_MODE_RESET 3'h0
`define CMP_MODE_OUTPUTS 3'h6
`define CMP_MODE_OFF 3'h7
`define CMP_ANALOG_MASK 6'h0f
`define VREF_PIN_MASK 6'h04
// Bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

//--- rtl/gpio_pkg.sv
// Types shared by the port block
package gpio_pkg;
    // Complete register state of the port block
    typedef struct packed {
        logic [5:0] first_latch;
        logic [5:0] first_dir;
        logic [2:0] cmp_mode;
        logic cmp_cis;
        logic [7:0] vref_ctl;
        logic [7:0] second_latch;
        logic [7:0] second_dir;
        logic [7:0] option;
        logic [3:0] old_upper;
        logic change_flag;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } gpio_state_t;
    // One group of pin drive signals
    typedef struct packed {
        logic [7:0] value;
        logic [7:0] oe_n;
    } pin_drive_t;
endpackage

//--- rtl/pin_sync.sv
// Three-stage input synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int W = 16
) (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // Raw and filtered levels
    input wire logic [W-1:0] raw_in,
    output logic [W-1:0] level_out
);
    // All stages in one packed state
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] lvl;
    } sync_state_t;
    sync_state_t q;
    sync_state_t d;

    // Stage one feeds stage two only; the filter looks at two and three
    always_comb begin
        d = q;
        d.s1 = raw_in;
        d.s2 = q.s1;
        d.s3 = q.s2;
        for (int i = 0; i < W; i++) begin
            if (q.s2[i] == q.s3[i]) begin
                d.lvl[i] = q.s3[i];
            end
        end
    end

    // State register
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign level_out = q.lvl;
endmodule // pin_sync
`default_nettype wire

//--- bench/pin_board.sv
// Board model: external drivers on both port pin groups
`timescale 1ns/1ps
`default_nettype none
module pin_board (
    // Design pin drive
    input wire logic [5:0] a_val_in,
    input wire logic [5:0] a_oe_n_in,
    input wire logic [7:0] b_val_in,
    input wire logic [7:0] b_oe_n_in,
    // Board drive levels
    input wire logic [5:0] ext_a_in,
    input wire logic [7:0] ext_b_in,
    // Resolved pin levels
    output logic [5:0] a_pin_out,
    output logic [7:0] b_pin_out
);
    // Driven bits follow the design, released bits follow the board
    always_comb begin
        a_pin_out = (~a_oe_n_in & a_val_in) | (a_oe_n_in & ext_a_in);
        // Bit four can only pull low, so a driven bit four reads low
        a_pin_out[4] = a_oe_n_in[4] ? ext_a_in[4] : 1'b0;
        b_pin_out = (~b_oe_n_in & b_val_in) | (b_oe_n_in & ext_b_in);
    end
endmodule // pin_board
`default_nettype wire

//--- bench/tb_top.sv
// Testbench: register traffic and pin stimulus for the port block
`timescale 1ns/1ps
`default_nettype none
`include "gpio_params.svh"
module tb_top;
    //----------------------------------------
    // Signals
    //----------------------------------------
    logic clk = 0, rst = 1, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
    logic [11:0] aw = 0, ar = 0;
    logic [31:0] wd = 0, rd;
    logic [5:0] ext_a = 0, pa_in, pa, pa_oe;
    logic [7:0] ext_b = 0, pb_in, pb, pb_oe, pull;
    logic awr, wr, bv, arr, rv, chg, wk;
    logic cmp1 = 0, cmp2 = 0;
    logic [31:0] rdat;
    int fail_count = 0, n_tests = 0, cyc = 0;
    always #10 clk = ~clk;
    dual_port_gpio dut_u (.core_clk_in(clk), .rst_in(rst), .s_axi_awaddr_in(aw),
        .s_axi_awvalid_in(awv), .s_axi_awready_out(awr), .s_axi_wdata_in(wd),
        .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wv), .s_axi_wready_out(wr),
        .s_axi_bresp_out(), .s_axi_bvalid_out(bv), .s_axi_bready_in(bre),
        .s_axi_araddr_in(ar), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
        .s_axi_rdata_out(rdat), .s_axi_rresp_out(), .s_axi_rvalid_out(rv),
        .s_axi_rready_in(rre), .first_pin_in(pa_in), .first_pin_out(pa),
        .first_pin_oe_n_out(pa_oe), .second_pin_in(pb_in), .second_pin_out(pb),
        .second_pin_oe_n_out(pb_oe), .second_pullup_en_out(pull),
        .comparator_one_result_in(cmp1), .comparator_two_result_in(cmp2),
        .analog_select_out(), .comparator_ground_out(), .comparator_mode_out(),
        .comparator_input_switch_out(), .vref_control_out(),
        .timer_external_clock_out(), .second_port_change_request_out(chg),
        .wake_request_out(wk));
    pin_board board_u (.a_val_in(pa), .a_oe_n_in(pa_oe), .b_val_in(pb),
        .b_oe_n_in(pb_oe), .ext_a_in(ext_a), .ext_b_in(ext_b),
        .a_pin_out(pa_in), .b_pin_out(pb_in));
    //----------------------------------------
    // Bus tasks and checks
    //----------------------------------------
    // Each channel is released only at the edge where it is taken
    task automatic wr_reg(input logic [7:0] idx, input logic [31:0] d);
        logic a_p, w_p, b_p;
        @(posedge clk);
        a_p = 1; w_p = 1; b_p = 1;
        aw <= {2'b00, idx, 2'b00}; wd <= d; awv <= 1; wv <= 1; bre <= 1;
        while (a_p | w_p | b_p) begin
            @(posedge clk);
            if (awr === 1'b1 && a_p) begin a_p = 0; awv <= 0; end
            if (wr === 1'b1 && w_p) begin w_p = 0; wv <= 0; end
            if (bv === 1'b1 && b_p) begin b_p = 0; bre <= 0; end
        end
    endtask
    task automatic rd_reg(input logic [7:0] idx);
        logic a_p, r_p;
        @(posedge clk);
        a_p = 1; r_p = 1;
        ar <= {2'b00, idx, 2'b00}; arv <= 1; rre <= 1;
        while (a_p | r_p) begin
            @(posedge clk);
            if (arr === 1'b1 && a_p) begin a_p = 0; arv <= 0; end
            if (rv === 1'b1 && r_p) begin r_p = 0; rd = rdat; rre <= 0; end
        end
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Hang guard, far above the length of the sequence
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin fail_count++; stop_test(); end
    end
    //----------------------------------------
    // Sequence
    //----------------------------------------
    initial begin
        ext_a <= 6'h3f;
        repeat (16) @(posedge clk);
        rst <= 0;
        repeat (2) @(posedge clk);
        rd_reg(`IDX_FIRST_DIR); chk(rd[7:0], 8'h3f);
        rd_reg(`IDX_SECOND_DIR); chk(rd[7:0], 8'hff);
        rd_reg(`IDX_VREF); chk(rd[7:0], 8'h00);
        chk(pull, 8'h00);
        // Comparator inputs in reset mode read as zero
        rd_reg(`IDX_FIRST_DATA); chk(rd[7:0], 8'h30);
        // Comparators off, all first pins driven from the latch
        wr_reg(`IDX_COMPARATOR, 32'h7);
        wr_reg(`IDX_FIRST_DIR, 32'h0);
        wr_reg(`IDX_FIRST_DATA, 32'h2a);
        repeat (8) @(posedge clk);
        rd_reg(`IDX_FIRST_DATA); chk(rd[7:0], 8'h2a);
        // Released pins show the board level, bit four included
        wr_reg(`IDX_FIRST_DIR, 32'h3f);
        ext_a <= 6'h15;
        repeat (8) @(posedge clk);
        rd_reg(`IDX_FIRST_DATA); chk(rd[7:0], 8'h15);
        // Reference output on bit two while its direction stays input
        wr_reg(`IDX_VREF, 32'hff);
        rd_reg(`IDX_VREF); chk(rd[7:0], 8'hef);
        // Comparator outputs reach bits three and four once driven
        cmp1 <= 1;
        wr_reg(`IDX_COMPARATOR, 32'h6);
        wr_reg(`IDX_FIRST_DIR, 32'h27);
        repeat (8) @(posedge clk);
        chk({6'h0, pa_in[4:3]}, 8'h01);
        rd_reg(`IDX_COMPARATOR); chk(rd[7:0], 8'h46);
        rd_reg(`IDX_FIRST_DATA); chk(rd[7:0], 8'h00);
        // Upper second pins inputs, pull-ups only on inputs
        wr_reg(`IDX_SECOND_DIR, 32'hf0);
        wr_reg(`IDX_OPTION, 32'h7f);
        chk(pull, 8'hf0);
        repeat (8) @(posedge clk);
        rd_reg(`IDX_SECOND_DATA);
        ext_b <= 8'h10;
        repeat (8) @(posedge clk);
        // Watch the flag, never poll the port, so the reference stands
        rd_reg(`IDX_CHANGE_CTRL); chk({7'h0, rd[0]}, 8'h01);
        chk({7'h0, chg}, 8'h01);
        chk({7'h0, wk}, 8'h01);
        // Reading the port ends the mismatch, then the flag clears
        rd_reg(`IDX_SECOND_DATA); chk(rd[7:0], 8'h10);
        wr_reg(`IDX_CHANGE_CTRL, 32'h0);
        rd_reg(`IDX_CHANGE_CTRL); chk({7'h0, rd[0]}, 8'h00);
        stop_test();
    end
endmodule // tb_top
`default_nettype wire
